/* File: bench/hmld_fifo_model.sv */
// far side stand-in: command fifo fill level and engine activity
// assumes the bench pulses load to queue words that drain one a cycle
`timescale 1ns/10ps
module hmld_fifo_model (
  input  wire logic       clk,        // host bus clock
  input  wire logic       rst_n,      // sync reset
  input  wire logic       load,       // queue a burst of words
  input  wire logic [3:0] words,      // burst length
  input  wire logic       busy_req,   // engine asked to run
  output logic            fifo_empty, // command fifo empty
  output logic            eng_busy    // engine active
);
  logic [4:0] level_reg; // words still queued
  // words drain one a cycle, so a held read really has to wait
  always_ff @(posedge clk) begin
    if (!rst_n) level_reg <= '0;
    else if (load) level_reg <= level_reg + {1'b0, words};
    else if (level_reg != '0) level_reg <= level_reg - 5'h01;
  end
  assign fifo_empty = (level_reg == '0);
  // engine runs one cycle after it is asked to
  always_ff @(posedge clk) eng_busy <= rst_n & busy_req;
endmodule

/* File: bench/tb_host_mmio_linear_decoder.sv */
// bench for the host address decoder with a behavioural address model
// assumes hmld_decoder in core/ and the fifo model beside this file
`timescale 1ns/10ps
module tb_host_mmio_linear_decoder;
  import hmld_pkg::*;
  logic clk = 0, rst_n = 0, pci = 1, v = 0, io = 0, wr = 0, hs = 0;
  logic [31:0] ad = 0, wd = 0, rwd, rdd;
  logic load = 0, busy_in = 0, fe, eb, rv, rw, rb, rh, rd;
  hmld_tgt_e rt;
  logic [23:0] ra;
  logic [3:0] rbe;
  logic [1:0] rs;
  int mismatches = 0, check_count = 0, wsel = 1, leg = 0, lb = -1, pg = 0;
  int seed = 32'h486f, a;
  always #4 clk = ~clk;
  hmld_fifo_model u_fifo (.clk(clk), .rst_n(rst_n), .load(load),
    .words(4'h5), .busy_req(busy_in), .fifo_empty(fe), .eng_busy(eb));
  hmld_decoder u_dut (.clk(clk), .rst_n(rst_n), .pci_mode(pci),
    .req_valid(v), .req_io(io), .req_write(wr), .req_addr(ad),
    .req_wdata(wd), .req_be(4'hF), .cmd_fifo_empty(fe),
    .engine_busy(eb), .resp_valid(rv), .resp_target(rt),
    .resp_addr(ra), .resp_write(rw), .resp_wdata(rwd), .resp_be(rbe),
    .resp_big(rb), .resp_swap(rs), .resp_rdata(rdd), .resp_hold(rh),
    .resp_disconnect(rd));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // one strobe, then wait a bounded time for the answer
  task automatic req(logic i, logic w, logic [31:0] x, logic [31:0] d);
    @(posedge clk);
    v <= 1; io <= i; wr <= w; ad <= x; wd <= d; load <= 0; hs = 0;
    for (int n = 0; n < 30; n++) begin
      @(posedge clk);
      v <= 0;
      #1;
      if (rh === 1) hs = 1;
      if (rv === 1) break;
    end
    if (rv !== 1) chk("answer", 1, 0);
  endtask
  // index write then data write on the crt port pair
  task automatic crt(logic [7:0] i, logic [7:0] d);
    req(1, 1, 'h3D4, i);
    req(1, 1, 'h3D5, d);
  endtask
  // expected target and offset; new window wins where both match
  function automatic void model(int x, logic w, output int t,
                                output int o);
    int g;
    int l;
    l = leg ? 'hB0000 : 'hA0000;
    t = 0;
    o = 0;
    if (wsel[0] && x < 'h4000000) g = x & 'h1FFFFFF;
    else if (wsel[1] && x >= l + leg * 'h8000 && x < l + 'h10000)
      g = x - l + 'h1000000;
    else if (lb >= 0 && x >= lb && x < lb + 'h10000) begin
      t = 1;
      o = x - lb + pg * 'h10000;
      return;
    end else return;
    o = g & 'hFFFF;
    if (g < 'h1000000) begin t = 1; o = g & 'h3FFFFF; end
    else if (g < 'h1008000) begin t = w ? 2 : 0; o = g & 'h7FFF; end
    else if (g >= 'h1010000) t = 0;
    else if (o == 'h8504 || o == 'h850C) t = 3;
    else if (o >= 'h83B0 && o <= 'h83DF) t = 4;
    else if (o >= 'hA400 && o <= 'hA5FF) t = 6;
    else if (o >= 'hFF00 && o <= 'hFF5C) t = 5;
    else if (o >= 'h8000 && o <= 'h8043) t = 7;
  endfunction
  task automatic mreq(int x, logic w);
    int t, o;
    model(x, w, t, o);
    req(0, w, x, 32'h5A5A0000 ^ x);
    chk("tgt", t, rt);
    if (t != 0) chk("addr", o, ra);
    chk("write", w, rw);
    if (w) chk("wdata", 32'h5A5A0000 ^ x, rwd);
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    mreq('h1008504, 1);
    @(posedge clk) busy_in <= 1;
    mreq('h1008504, 0);
    chk("busy", 1, rdd[13]);
    mreq('h3008504, 0);
    chk("big", 1, rb);
    crt('h66, 'h01);
    crt('h31, 'h08);
    @(posedge clk) busy_in <= 0;
    mreq('h1008504, 0);
    chk("idle", 0, rdd[13]);
    crt('h58, 'h10);
    lb = 0;
    a = $random(seed) & 'h3FFFFC;
    mreq(a, 1);
    crt('h53, 'h0C);
    mreq('h2000000 | a, 0);
    chk("swap", 2, rs);
    mreq('h1000000 | a[14:0], 1);
    mreq('h1008100, 1);
    mreq('h100A500, 1);
    mreq('h100FF10, 0);
    mreq('h1008010, 1);
    mreq('h1018504, 0);
    @(posedge clk) load <= 1;
    mreq('h10083C0, 0);
    chk("hold", 1, hs);
    req(1, 1, 'h3D4, 'h66);
    req(1, 1, 'h3D5, 'h09);
    @(posedge clk) load <= 1;
    req(0, 0, 'h10083C0, 0);
    chk("disc", 1, rd);
    req(1, 1, 'h3D4, 'h53);
    req(1, 1, 'h3D5, 'h10);
    wsel = 2;
    mreq('hA8504, 0);
    mreq('hA7FFC, 1);
    mreq('h1008504, 1);
    req(1, 1, 'h3D5, 'h30);
    leg = 1;
    mreq('hB8504, 0);
    mreq('hA0010, 1);
    crt('h5A, 'h0A);
    crt('h6A, 'h03);
    crt('h31, 'h09);
    lb = 'hA0000;
    pg = 3;
    mreq('hA1234, 0);
    crt('h53, 'h18);
    wsel = 3;
    mreq('h1000020, 1);
    req(1, 1, 'h3C4, 'h09);
    req(1, 1, 'h3C5, 'h80);
    req(1, 0, 'h3D4, 0);
    chk("pio", 0, rt);
    @(posedge clk) begin rst_n <= 0; pci <= 0; end
    repeat (4) @(posedge clk);
    rst_n <= 1;
    wsel = 0;
    lb = -1;
    pg = 0;
    mreq('h1008504, 0);
    complete_run;
  end
endmodule

/* File: core/hmld_decoder.sv */
// host address decoder: memory windows, linear addressing, port i/o
// assumes one-cycle request strobes from the host bus interface and
// fifo status levels from logic on the same clock
`timescale 1ns/10ps
module hmld_decoder (
  input  wire logic                    clk,             // host bus clock
  input  wire logic                    rst_n,           // sync reset
  input  wire logic                    pci_mode,        // strap: 1 = pci
  input  wire logic                    req_valid,       // request strobe
  input  wire logic                    req_io,          // port i/o cycle
  input  wire logic                    req_write,       // 1 = write
  input  wire logic [31:0]             req_addr,        // byte address
  input  wire logic [hmld_pkg::DATA_W-1:0] req_wdata,   // write data
  input  wire logic [3:0]              req_be,          // byte enables
  input  wire logic                    cmd_fifo_empty,  // command fifo
  input  wire logic                    engine_busy,     // engine active
  output logic                         resp_valid,      // answer strobe
  output hmld_pkg::hmld_tgt_e          resp_target,     // decoded target
  output logic [hmld_pkg::RADDR_W-1:0] resp_addr,       // internal addr
  output logic                         resp_write,      // 1 = write
  output logic [hmld_pkg::DATA_W-1:0]  resp_wdata,      // write data
  output logic [3:0]                   resp_be,         // byte enables
  output logic                         resp_big,        // big-endian half
  output logic [1:0]                   resp_swap,       // swap mode
  output logic [hmld_pkg::DATA_W-1:0]  resp_rdata,      // local read data
  output logic                         resp_hold,       // read held
  output logic                         resp_disconnect  // retry answer
);
  import hmld_pkg::*;

  // control registers
  logic [7:0]  mem_cfg_reg;        // memory_config_control
  logic [7:0]  mmc_reg;            // memory_mapping_control
  logic [7:0]  lin_ctl_reg;        // linear_window_control
  logic [7:0]  pos_hi_reg;         // window_position_high
  logic [7:0]  pos_lo_reg;         // window_position_low
  logic [7:0]  bus_ctl_reg;        // enhanced_bus_control
  logic [7:0]  page_reg;           // bank_page_number
  logic [7:0]  pio_ctl_reg;        // port_io_disable_ctrl
  logic [31:0] adv_func_reg;       // advanced_function_control
  logic [7:0]  crt_idx_reg;        // crt index shadow
  logic [7:0]  seq_idx_reg;        // sequencer index shadow
  // held read
  logic        pend_reg;           // a read waits for the fifo
  hmld_tgt_e   pend_tgt_reg;       // its target
  logic [RADDR_W-1:0] pend_addr_reg; // its address
  logic [3:0]  pend_be_reg;        // its byte enables
  // decode results
  hmld_tgt_e   d_tgt;              // decoded target
  logic [RADDR_W-1:0] d_addr;      // decoded internal address
  logic        d_big;              // big-endian half
  logic [1:0]  d_swap;             // swap mode for the answer
  logic [31:0] d_rdata;            // local read data
  logic        acc;                // request taken this cycle
  logic        need_hold;          // read must wait for the fifo
  logic        disc_en;            // pci retries instead of holding
  logic [1:0]  wsel;               // window select
  logic [31:0] lin_base;           // linear window base
  logic [31:0] lin_mask;           // linear window offset bits
  logic [22:0] lin_sum;            // banked display address
  logic [15:0] io_a;               // port address
  logic [15:0] leg_off;            // legacy window offset

  assign wsel = mmc_reg[MMC_WSEL_LSB +: 2];
  assign acc  = req_valid && !pend_reg; // held reads stall the host
  assign io_a = req_addr[15:0];

  // register group of a variable offset; gaps give none
  function automatic hmld_tgt_e reg_group(input logic [15:0] off);
    hmld_tgt_e g;
    g = TGT_NONE;                                   // see R11
    if (off == REG_ENG_STATUS[15:0] || off == REG_ADV_FUNC[15:0])
      g = TGT_LOCAL;
    else if ((off >= RG_CFG_LO && off <= RG_CFG_HI) ||
             (off >= RG_STR_LO && off <= RG_STR_HI) ||
             (off >= RG_MPC_LO && off <= RG_MPC_HI) ||
             (off >= RG_DMA_LO && off <= RG_DMA_HI))
      g = TGT_OTHER;
    else if (off >= RG_VGA_LO && off <= RG_VGA_HI)
      g = TGT_VGA;
    else if (off >= RG_ENG_LO && off <= RG_ENG_HI &&
             off[9] == 1'b0)                        // see R10
      g = TGT_ENGINE;  // 1K blocks, upper half of each is a gap
    else if (off >= RG_LPB_LO && off <= RG_LPB_HI)
      g = TGT_LPB;
    return g;
  endfunction

  // offset bits covered by the linear window size field
  function automatic logic [31:0] size_mask(input logic [1:0] sz);
    logic [31:0] m;
    m = 32'h0000_FFFF;                              // 64K
    if (sz == 2'h1)
      m = 32'h000F_FFFF;                            // 1M
    else if (sz == 2'h2)
      m = 32'h001F_FFFF;                            // 2M
    else if (sz == 2'h3)
      m = 32'h003F_FFFF;                            // 4M
    return m;
  endfunction

  // old linear window base and banked address
  always_comb begin
    lin_base = {pos_hi_reg, pos_lo_reg, 16'h0000}; // see R16
    lin_mask = size_mask(lin_ctl_reg[1:0]);          // see R16
    lin_sum  = {1'b0, req_addr[LIN_W-1:0] & lin_mask[LIN_W-1:0]};
    if (mem_cfg_reg[BANK_EN_BIT])                    // see R17
      lin_sum = lin_sum + {1'b0, page_reg[5:0], 16'h0000};
  end

  // address decode, one request per cycle
  always_comb begin
    d_tgt   = TGT_NONE;
    d_addr  = '0;
    d_big   = 1'b0;
    d_swap  = 2'h0;
    d_rdata = '0;
    leg_off = 16'h0000;
    if (req_io) begin
      // port cycles are dropped once blocked under a window  see R8
      if (!(wsel != WSEL_NONE && pio_ctl_reg[PIO_DIS_BIT])) begin
        if (io_a == IO_CRT_IDX || io_a == IO_SEQ_IDX) begin
          d_tgt   = TGT_LOCAL;
          d_rdata = {24'h0, io_a == IO_CRT_IDX ? crt_idx_reg
                                               : seq_idx_reg};
        end else if (io_a == IO_SEQ_DAT && seq_idx_reg == IDX_PIO_CTL)
        begin
          d_tgt   = TGT_LOCAL;
          d_rdata = {24'h0, pio_ctl_reg};
        end else if (io_a == IO_CRT_DAT && (crt_idx_reg == IDX_MEM_CFG
                   || crt_idx_reg == IDX_MMC || crt_idx_reg == IDX_LIN_CTL
                   || crt_idx_reg == IDX_POS_HI || crt_idx_reg == IDX_POS_LO
                   || crt_idx_reg == IDX_BUS_CTL || crt_idx_reg == IDX_PAGE))
        begin
          d_tgt = TGT_LOCAL;
          unique case (crt_idx_reg)
            IDX_MEM_CFG: d_rdata = {24'h0, mem_cfg_reg};
            IDX_MMC:     d_rdata = {24'h0, mmc_reg};
            IDX_LIN_CTL: d_rdata = {24'h0, lin_ctl_reg};
            IDX_POS_HI:  d_rdata = {24'h0, pos_hi_reg};
            IDX_POS_LO:  d_rdata = {24'h0, pos_lo_reg};
            IDX_BUS_CTL: d_rdata = {24'h0, bus_ctl_reg};
            default:     d_rdata = {24'h0, page_reg};
          endcase
        end else if (io_a >= IO_VGA_LO && io_a <= IO_VGA_HI) begin
          d_tgt  = TGT_VGA;  // other vga ports, index in the top byte
          d_addr = {io_a == IO_SEQ_DAT ? seq_idx_reg : crt_idx_reg, io_a};
        end
      end
    end else if (wsel[0] && req_addr[31:26] == pos_hi_reg[7:2]) begin
      // new window: 32M little half, then 32M big alias  see R9 R12
      d_big = req_addr[25];
      if (!req_addr[24]) begin
        // first 16M of the half is linear, 4M usable  see R19 R14
        if (lin_ctl_reg[LIN_EN_BIT] && req_addr[23:LIN_W] == 2'h0) begin
          d_tgt  = TGT_LINEAR;
          d_addr = {2'h0, req_addr[LIN_W-1:0]};
          d_swap = req_addr[25] ? mmc_reg[MMC_SWAP_LSB +: 2] : 2'h0;
        end                                         // see R20
      end else if (req_addr[23:16] == 8'h00) begin
        if (req_addr[15:0] <= IMG_TOP) begin
          if (req_write) begin                      // see R10
            d_tgt  = TGT_IMAGE;
            d_addr = {9'h0, req_addr[14:0]};
          end
        end else begin
          d_tgt  = reg_group(req_addr[15:0]);       // see R10 R11
          d_addr = {8'h00, req_addr[15:0]};
        end
      end
    end else if (wsel[1] && ((!mmc_reg[MMC_LEG_HI] &&
               req_addr[31:16] == LEG_LOW_SEG) ||
               (mmc_reg[MMC_LEG_HI] &&
               req_addr[31:15] == LEG_HIGH_SEG))) begin
      // legacy window; the high placement is only the register half
      leg_off = mmc_reg[MMC_LEG_HI] ? {1'b1, req_addr[14:0]}
                                    : req_addr[15:0];  // see R4
      if (leg_off <= IMG_TOP) begin
        if (req_write) begin                        // see R6
          d_tgt  = TGT_IMAGE;
          d_addr = {9'h0, leg_off[14:0]};
        end
      end else begin
        d_tgt  = reg_group(leg_off);                // see R5
        d_addr = {8'h00, leg_off};
      end
    end else if (!wsel[0] && lin_ctl_reg[LIN_EN_BIT] &&
               (req_addr & ~lin_mask) == (lin_base & ~lin_mask)) begin
      // old linear window, only without the new window
      if (!lin_sum[LIN_W]) begin                    // see R14
        d_tgt  = TGT_LINEAR;
        d_addr = {2'h0, lin_sum[LIN_W-1:0]};
      end
    end
    // local memory-mapped registers
    if (!req_io && d_tgt == TGT_LOCAL) begin
      if (d_addr[15:0] == REG_ENG_STATUS[15:0])
        d_rdata = 32'(engine_busy) << ENG_BUSY_BIT; // see R15
      else
        d_rdata = adv_func_reg;
    end
  end

  // vga and peripheral reads wait for the command fifo  see R22
  assign need_hold = !req_write && !cmd_fifo_empty &&
                     (d_tgt == TGT_VGA || d_tgt == TGT_LPB);
  assign disc_en   = pci_mode && bus_ctl_reg[BUS_DISC_BIT]; // see R22

  // window select resets by the bus strap, pci or vl-bus
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mmc_reg <= pci_mode ? {3'h0, WSEL_NEW, 3'h0}   // see R2
                          : {3'h0, WSEL_NONE, 3'h0}; // see R3
    end else if (acc && req_io && req_write && d_tgt == TGT_LOCAL &&
                 io_a == IO_CRT_DAT && crt_idx_reg == IDX_MMC) begin
      mmc_reg <= req_wdata[7:0];                    // see R1
    end
  end

  // indexed control registers written through the data port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_cfg_reg <= RST_CTRL;
      lin_ctl_reg <= RST_CTRL;
      pos_hi_reg  <= RST_CTRL;
      pos_lo_reg  <= RST_CTRL;
      bus_ctl_reg <= RST_CTRL;
      page_reg    <= RST_CTRL;
      pio_ctl_reg <= RST_CTRL;
      crt_idx_reg <= RST_CTRL;
      seq_idx_reg <= RST_CTRL;
    end else if (acc && req_io && req_write && d_tgt == TGT_LOCAL) begin
      if (io_a == IO_CRT_IDX)
        crt_idx_reg <= req_wdata[7:0];
      else if (io_a == IO_SEQ_IDX)
        seq_idx_reg <= req_wdata[7:0];
      else if (io_a == IO_SEQ_DAT)
        pio_ctl_reg <= req_wdata[7:0];              // see R8
      else begin
        // software is trusted to set the enhanced bits first
        unique case (crt_idx_reg)
          IDX_MEM_CFG: mem_cfg_reg <= req_wdata[7:0]; // see R13
          IDX_LIN_CTL: lin_ctl_reg <= req_wdata[7:0]; // see R16
          IDX_POS_HI:  pos_hi_reg  <= req_wdata[7:0];
          IDX_POS_LO:  pos_lo_reg  <= req_wdata[7:0];
          IDX_BUS_CTL: bus_ctl_reg <= req_wdata[7:0];
          IDX_PAGE:    page_reg    <= req_wdata[7:0]; // see R17
          default:     ;  // mapping control has its own process
        endcase
      end
    end
  end

  // advanced function control, byte-lane writes over the window
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      adv_func_reg <= RST_AFC;
    end else if (acc && !req_io && req_write && d_tgt == TGT_LOCAL &&
                 d_addr[15:0] == REG_ADV_FUNC[15:0]) begin
      for (int i = 0; i < 4; i++)
        if (req_be[i])
          adv_func_reg[8*i +: 8] <= req_wdata[8*i +: 8];
    end
  end

  // held read: parks the request until the fifo drains
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_reg      <= 1'b0;
      pend_tgt_reg  <= TGT_NONE;
      pend_addr_reg <= '0;
      pend_be_reg   <= 4'h0;
    end else if (pend_reg) begin
      if (cmd_fifo_empty)
        pend_reg <= 1'b0;                           // see R22
    end else if (acc && need_hold && !disc_en) begin // see R22
      pend_reg      <= 1'b1;
      pend_tgt_reg  <= d_tgt;
      pend_addr_reg <= d_addr;
      pend_be_reg   <= req_be;
    end
  end

  // answer register; every output comes from here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resp_valid      <= 1'b0;
      resp_target     <= TGT_NONE;
      resp_addr       <= '0;
      resp_write      <= 1'b0;
      resp_wdata      <= '0;
      resp_be         <= 4'h0;
      resp_big        <= 1'b0;
      resp_swap       <= 2'h0;
      resp_rdata      <= '0;
      resp_hold       <= 1'b0;
      resp_disconnect <= 1'b0;
    end else if (pend_reg) begin
      // release the parked read once the fifo is empty
      resp_valid      <= cmd_fifo_empty;
      resp_hold       <= !cmd_fifo_empty;
      resp_target     <= pend_tgt_reg;
      resp_addr       <= pend_addr_reg;
      resp_be         <= pend_be_reg;
      resp_write      <= 1'b0;
      resp_disconnect <= 1'b0;
    end else if (acc && need_hold && disc_en) begin
      // retry instead of holding the bus                see R22
      resp_valid      <= 1'b1;
      resp_target     <= TGT_NONE;
      resp_disconnect <= 1'b1;
      resp_hold       <= 1'b0;
      resp_write      <= 1'b0;
    end else begin
      resp_valid      <= acc && !need_hold;
      resp_hold       <= acc && need_hold;
      resp_disconnect <= 1'b0;
      resp_target     <= acc ? d_tgt : TGT_NONE;
      resp_addr       <= d_addr;
      resp_write      <= acc && req_write;
      resp_wdata      <= req_wdata;
      resp_be         <= req_be;
      resp_big        <= d_big;
      resp_swap       <= d_swap;
      resp_rdata      <= d_rdata;
    end
  end

  // window select follows the bus strap out of reset
  sel_reset_a: assert property (@(posedge clk) // see R2 R3
    !$past(rst_n) && rst_n |->
      mmc_reg[4:3] == ($past(pci_mode) ? WSEL_NEW : WSEL_NONE))
    else $error("window select wrong after reset");
  // image target only ever comes from a write
  img_write_a: assert property (@(posedge clk) disable iff (!rst_n) // see R6
    resp_valid && resp_target == TGT_IMAGE |-> resp_write) // see R6
    else $error("image target on a read");
  // blocked port cycles reach nothing
  io_block_a: assert property (@(posedge clk) disable iff (!rst_n) // see R8
    acc && req_io && wsel != WSEL_NONE && pio_ctl_reg[PIO_DIS_BIT]
    |=> resp_valid && resp_target == TGT_NONE) // see R8
    else $error("port i/o passed while disabled");
  // linear addresses stay inside display memory
  lin_cap_a: assert property (@(posedge clk) disable iff (!rst_n) // see R14
    resp_valid && resp_target == TGT_LINEAR |->
      resp_addr[RADDR_W-1:LIN_W] == 2'h0) // see R14
    else $error("linear address beyond 4 MBytes");
  // big-endian linear carries the programmed swap
  swap_big_a: assert property (@(posedge clk) disable iff (!rst_n) // see R20
    acc && !req_io && d_tgt == TGT_LINEAR && req_addr[25] && wsel[0]
    |=> resp_big && resp_swap == $past(mmc_reg[2:1])) // see R20
    else $error("big-endian swap not applied");
  // the upper 16M outside the image and register 64K decodes to nothing
  gap_none_a: assert property (@(posedge clk) disable iff (!rst_n) // see R11
    acc && !req_io && wsel == WSEL_NEW &&
    req_addr[31:26] == pos_hi_reg[7:2] && req_addr[24] &&
    req_addr[23:16] != 8'h00 |=> resp_target == TGT_NONE) // see R11
    else $error("reserved gap decoded");
  // parked read answers in the cycle after the fifo drains
  hold_rel_a: assert property (@(posedge clk) disable iff (!rst_n) // see R22
    pend_reg && cmd_fifo_empty |=> resp_valid && !resp_hold) // see R22
    else $error("held read not released");

  // disconnect only with the bus control bit set
  disc_bit_a: assert property (@(posedge clk) disable iff (!rst_n) // see R22
    resp_disconnect |-> resp_valid &&
      $past(bus_ctl_reg[BUS_DISC_BIT]) && !$past(cmd_fifo_empty))
    else $error("disconnect without cause"); // see R22
endmodule

/* File: core/hmld_pkg.sv */
// constants, field positions, reset values and target codes for the host
// address decoder; assumes a single host-bus clock and byte addresses
// Operation
// R1 - 10b enables legacy window, 11b both
// R2 - 01b decodes new window only; PCI default
// R3 - VL-Bus resets window select to 00b
// R4 - legacy base at A0000H or B8000H
// R5 - all registers reachable through legacy window
// R6 - low legacy 32K below A8000H takes image writes
// R7 - host makes aligned image writes below A7FFFH
// R8 - port-I/O disable bit blocks port cycles; the code blocks them only while window select is not 00b
// R9 - new window 64M: little then big half
// R10 - new window linear, image, register sub-ranges
// R11 - gaps between ranges are reserved, unused
// R12 - big-endian alias adds 2 to top digit
// R13 - host enables enhanced bits before linear
// R14 - linear access limited to 4 MBytes
// R15 - engine busy in status bit 13
// R16 - size field and position registers set window
// R17 - banking adds 64K page to base
// R18 - host sets 64K window at A0000H
// R19 - new linear: base 31-26 plus offset
// R20 - big-endian linear uses swap field
// R21 - host orders accesses across the FIFOs
// R22 - held reads; disconnect when bus bit 3; the code disconnects only when pci_mode is also set
package hmld_pkg;
  localparam int DATA_W  = 32;                   // host data width
  localparam int RADDR_W = 24;                   // forwarded address width
  localparam int LIN_W   = 22;                   // 4 MByte display memory
  // memory mapping control fields
  localparam int MMC_SWAP_LSB = 1;               // byte swap field 2-1
  localparam int MMC_WSEL_LSB = 3;               // window select field 4-3
  localparam int MMC_LEG_HI   = 5;               // legacy base select bit
  localparam logic [1:0] WSEL_NONE = 2'h0;       // no window
  localparam logic [1:0] WSEL_NEW  = 2'h1;       // new window only
  localparam logic [1:0] WSEL_OLD  = 2'h2;       // legacy window only
  localparam logic [1:0] WSEL_BOTH = 2'h3;       // both windows
  localparam int PIO_DIS_BIT  = 7;               // port i/o disable
  localparam int ENH_EN_BIT   = 0;               // enhanced functions
  localparam int ENH_MAP_BIT  = 3;               // enhanced mapping
  localparam int BANK_EN_BIT  = 0;               // 64K banking enable
  localparam int LIN_EN_BIT   = 4;               // linear enable
  localparam int BUS_DISC_BIT = 3;               // disconnect on hold
  localparam int ENG_BUSY_BIT = 13;              // engine busy status
  localparam logic [7:0] RST_CTRL = 8'h00;       // control reset value
  localparam logic [31:0] RST_AFC = 32'h0000_0000; // adv function reset
  // indexed register numbers
  localparam logic [7:0] IDX_MEM_CFG  = 8'h31;   // memory config
  localparam logic [7:0] IDX_MMC      = 8'h53;   // mapping control
  localparam logic [7:0] IDX_LIN_CTL  = 8'h58;   // linear window ctl
  localparam logic [7:0] IDX_POS_HI   = 8'h59;   // position 31-24
  localparam logic [7:0] IDX_POS_LO   = 8'h5A;   // position 23-16
  localparam logic [7:0] IDX_BUS_CTL  = 8'h66;   // enhanced bus ctl
  localparam logic [7:0] IDX_PAGE     = 8'h6A;   // bank page number
  localparam logic [7:0] IDX_PIO_CTL  = 8'h09;   // port i/o control
  // port i/o addresses
  localparam logic [15:0] IO_SEQ_IDX  = 16'h03C4; // sequencer index
  localparam logic [15:0] IO_SEQ_DAT  = 16'h03C5; // sequencer data
  localparam logic [15:0] IO_CRT_IDX  = 16'h03D4; // crt index
  localparam logic [15:0] IO_CRT_DAT  = 16'h03D5; // crt data
  localparam logic [15:0] IO_VGA_LO   = 16'h03B0; // vga i/o low
  localparam logic [15:0] IO_VGA_HI   = 16'h03DF; // vga i/o high
  // legacy window placement
  localparam logic [15:0] LEG_LOW_SEG  = 16'h000A; // A0000H-AFFFFH
  localparam logic [16:0] LEG_HIGH_SEG = 17'h00017; // B8000H-BFFFFH
  localparam logic [15:0] IMG_TOP      = 16'h7FFF; // image top offset
  localparam logic [15:0] REG_BASE_OFF = 16'h8000; // register area
  // local registers inside the register area
  localparam logic [25:0] REG_ENG_STATUS = 26'h100_8504; // status
  localparam logic [25:0] REG_ADV_FUNC   = 26'h100_850C; // adv func
  // register group ranges, variable part of the offset
  localparam logic [15:0] RG_CFG_LO = 16'h8000, RG_CFG_HI = 16'h8043;
  localparam logic [15:0] RG_STR_LO = 16'h8180, RG_STR_HI = 16'h81FF;
  localparam logic [15:0] RG_MPC_LO = 16'h8200, RG_MPC_HI = 16'h8224;
  localparam logic [15:0] RG_VGA_LO = 16'h83B0, RG_VGA_HI = 16'h83DF;
  localparam logic [15:0] RG_DMA_LO = 16'h8580, RG_DMA_HI = 16'h85FF;
  localparam logic [15:0] RG_ENG_LO = 16'hA000, RG_ENG_HI = 16'hB5FF;
  localparam logic [15:0] RG_LPB_LO = 16'hFF00, RG_LPB_HI = 16'hFF5C;
  typedef enum logic [2:0] {
    TGT_NONE   = 3'b000,  // reserved or not decoded
    TGT_LINEAR = 3'b001,  // display memory, command fifo path
    TGT_IMAGE  = 3'b010,  // image data, engine fifo path
    TGT_LOCAL  = 3'b011,  // register held in this block
    TGT_VGA    = 3'b100,  // vga register path
    TGT_LPB    = 3'b101,  // local_peripheral_path registers
    TGT_ENGINE = 3'b110,  // drawing engine registers
    TGT_OTHER  = 3'b111   // other register groups
  } hmld_tgt_e;
endpackage
